/* include/cdu_pkg.sv */
// Constants and types for the configuration download and update block.
// Assumes a 250 MHz system clock and a byte-wide register access port.
`default_nettype none
package cdu_pkg;
  localparam int          CLK_MHZ         = 250;
  localparam int          PAGE_BYTES      = 32;
  localparam int          NUM_PAGES       = 16;
  localparam int          CFG_PAGES       = 7;
  localparam int          NV_BYTES        = PAGE_BYTES * NUM_PAGES;
  localparam int          CFG_BYTES       = PAGE_BYTES * CFG_PAGES;
  localparam int          NV_AW           = 9;
  localparam int          CFG_AW          = 8;
  localparam int          PAGE_AW         = 4;
  localparam int          BYTE_AW         = 5;
  // Engine start delay after download, in units of 100 us
  localparam int          ENG_DLY_100US   = 5;
  localparam int          ENG_DLY_CYC     = (ENG_DLY_100US * 100 * CLK_MHZ) / 1;
  localparam logic [7:0]  UPD_RESET       = 8'h00;
  localparam int          UPD_TRANSP_BIT  = 0;
  localparam int          UPD_COMMIT_BIT  = 1;
  localparam int          UPD_ERASE_BIT   = 2;
  localparam logic [7:0]  UPD_RD_MASK     = 8'h05;
  localparam logic [7:0]  BLANK_BYTE      = 8'hFF;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
  localparam logic [CFG_AW-1:0] CFG_LAST  = 8'(CFG_BYTES - 1);
  localparam logic [BYTE_AW-1:0] PAGE_LAST = 5'(PAGE_BYTES - 1);
  localparam logic [2:0]  RELOAD_BIT_MASK = 3'h1;
  typedef enum logic [3:0] {
    CDU_WAIT   = 4'h1,
    CDU_LOAD   = 4'h2,
    CDU_DELAY  = 4'h4,
    CDU_RUN    = 4'h8
  } cdu_state_t;
endpackage : cdu_pkg
`default_nettype wire

/* logic/cdu_top.sv */
// Configuration download/update: NV cell, staged and active latches.
// Assumes an SMBus slave front end presents decoded byte accesses.
//
// Function
// - Each setting is a staging/active latch pair
// - Rebuild latches from nonvolatile memory each power-up
// - Start download only after supply lockout release
// - Fill staging first, then copy all together
// - Wait fixed delay, then start sequencing engine
// - Refuse bus transactions while download runs
// - Transparent mode: writes take effect immediately
// - Staged mode: writes change staging only
// - Nonvolatile rewrite leaves latches untouched
// - Requested reload overwrites latch changes
// - Control bit 0 set makes latches transparent
// - Control bit 0 clear loads staging only
// - Control bit 1 write gives one commit pulse
// - Nonvolatile writes follow the same staging scheme
// - Erase enable gates page erase to all ones
// - Reload trigger copies pages 0 to 6
// - Sixteen pages of 32 bytes, pages 0-6 config
`timescale 1ns/1ps
`default_nettype none
module cdu_top
  import cdu_pkg::*;
#(
  parameter int ENG_DELAY = cdu_pkg::ENG_DLY_CYC
)(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Supply monitor
  input  wire logic                        supply_lockout_level,
  // Decoded bus access
  input  wire logic                        bus_start,
  input  wire logic                        cfg_wr,
  input  wire logic                        nv_wr,
  input  wire logic                        nv_erase,
  input  wire logic                        ctl_wr,
  input  wire logic                        reload_wr,
  input  wire logic [cdu_pkg::NV_AW-1:0]   addr,
  input  wire logic [7:0]                  wdata,
  input  wire logic                        rd,
  input  wire logic                        rd_nv,
  input  wire logic                        rd_ctl,
  // Bus answers
  output logic                             bus_nack,
  output logic [7:0]                       rdata,
  // Configuration and engine
  output logic [cdu_pkg::CFG_BYTES*8-1:0]  cfg_active,
  output logic                             cfg_ready,
  output logic                             sequencing_engine_start
);
  import cdu_pkg::*;

  logic [7:0] nv_mem [NV_BYTES];
  logic [7:0] stage_r [CFG_BYTES];
  logic [7:0] active_r [CFG_BYTES];
  logic [7:0] nv_stage_r;
  logic [NV_AW-1:0] nv_stage_addr_r;
  logic nv_stage_vld_r;

  cdu_state_t state_r, state_nxt;
  logic [CFG_AW-1:0] idx_r, idx_nxt;
  logic [31:0] dly_r, dly_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic commit_r, commit_nxt;
  logic xfer_r, xfer_nxt;
  logic nack_r, nack_nxt;
  logic start_r, start_nxt;
  logic ready_r, ready_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic erase_go;
  logic [PAGE_AW-1:0] erase_page;
  logic loading;
  logic [7:0] load_byte;

  assign loading    = (state_r == CDU_LOAD);
  assign erase_go   = nv_erase && ctl_r[UPD_ERASE_BIT] && !nack_r;
  assign erase_page = addr[NV_AW-1 -: PAGE_AW];
  assign load_byte  = nv_mem[idx_r];

  always_comb
  begin
    state_nxt  = state_r;
    idx_nxt    = idx_r;
    dly_nxt    = dly_r;
    xfer_nxt   = 1'b0;
    start_nxt  = 1'b0;
    ready_nxt  = ready_r;
    case (state_r)
      CDU_WAIT:
      begin
        if (supply_lockout_level)
        begin
          state_nxt = CDU_LOAD;
          idx_nxt   = '0;
        end
      end
      CDU_LOAD:
      begin
        if (idx_r == CFG_LAST)
        begin
          state_nxt = ready_r ? CDU_RUN : CDU_DELAY;
          xfer_nxt  = 1'b1;
          dly_nxt   = '0;
          ready_nxt = 1'b1;
        end
        else
          idx_nxt = idx_r + 8'h01;
      end
      CDU_DELAY:
      begin
        if (dly_r == 32'(ENG_DELAY - 1))
        begin
          state_nxt = CDU_RUN;
          start_nxt = 1'b1;
        end
        else
          dly_nxt = dly_r + 32'h1;
      end
      CDU_RUN:
      begin
        if (reload_wr && (wdata[2:0] & RELOAD_BIT_MASK) != 3'h0)
        begin
          state_nxt = CDU_LOAD;
          idx_nxt   = '0;
        end
      end
      default:
        state_nxt = CDU_WAIT;
    endcase
  end

  always_comb
  begin
    ctl_nxt    = ctl_r;
    commit_nxt = 1'b0;
    nack_nxt   = (state_nxt == CDU_WAIT) || (state_nxt == CDU_LOAD && !ready_nxt);
    rdata_nxt  = rdata_r;
    if (ctl_wr && !nack_r)
    begin
      ctl_nxt    = wdata & UPD_RD_MASK;
      commit_nxt = wdata[UPD_COMMIT_BIT];
    end
    if (rd && !nack_r)
    begin
      if (rd_ctl)
        rdata_nxt = ctl_r;
      else if (rd_nv)
        rdata_nxt = nv_mem[addr];
      else if (addr < NV_AW'(CFG_BYTES))
        rdata_nxt = active_r[addr[CFG_AW-1:0]];
      else
        rdata_nxt = ZERO_BYTE;
    end
  end

  // Staged NV byte, committed with the same pulse as the latches
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      nv_stage_r      <= ZERO_BYTE;
      nv_stage_addr_r <= '0;
      nv_stage_vld_r  <= 1'b0;
    end
    else if (nv_wr && !nack_r && !ctl_r[UPD_TRANSP_BIT])
    begin
      nv_stage_r      <= wdata;
      nv_stage_addr_r <= addr;
      nv_stage_vld_r  <= 1'b1;
    end
    else if (commit_r)
      nv_stage_vld_r  <= 1'b0;
  end

  // NV cell; no reset since it models nonvolatile storage
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < NV_BYTES; i++)
    begin
      if (erase_go && i[NV_AW-1 -: PAGE_AW] == erase_page)
        nv_mem[i] <= BLANK_BYTE;
    end
    if (nv_wr && !nack_r && ctl_r[UPD_TRANSP_BIT])
      nv_mem[addr] <= nv_mem[addr] & wdata;
    else if (commit_r && nv_stage_vld_r)
      nv_mem[nv_stage_addr_r] <= nv_mem[nv_stage_addr_r] & nv_stage_r;
  end

  genvar g;
  generate
    for (g = 0; g < CFG_BYTES; g++)
    begin : g_latch
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
          stage_r[g] <= ZERO_BYTE;
        else if (loading && idx_r == CFG_AW'(g))
          stage_r[g] <= load_byte;
        else if (cfg_wr && !nack_r && addr == NV_AW'(g))
          stage_r[g] <= wdata;
      end
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
          active_r[g] <= ZERO_BYTE;
        else if (xfer_r || commit_r)
          active_r[g] <= stage_r[g];
        else if (ctl_r[UPD_TRANSP_BIT] && cfg_wr && !nack_r && addr == NV_AW'(g))
          active_r[g] <= wdata;
      end
      assign cfg_active[g*8 +: 8] = active_r[g];
    end
  endgenerate

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r  <= CDU_WAIT;
      idx_r    <= '0;
      dly_r    <= '0;
      ctl_r    <= UPD_RESET;
      commit_r <= 1'b0;
      xfer_r   <= 1'b0;
      nack_r   <= 1'b1;
      start_r  <= 1'b0;
      ready_r  <= 1'b0;
      rdata_r  <= ZERO_BYTE;
    end
    else
    begin
      state_r  <= state_nxt;
      idx_r    <= idx_nxt;
      dly_r    <= dly_nxt;
      ctl_r    <= ctl_nxt;
      commit_r <= commit_nxt;
      xfer_r   <= xfer_nxt;
      nack_r   <= nack_nxt;
      start_r  <= start_nxt;
      ready_r  <= ready_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign bus_nack                = nack_r;
  assign rdata                   = rdata_r;
  assign cfg_ready               = ready_r;
  assign sequencing_engine_start = start_r;

  a_nack_during_load: assert property (@(posedge clock) disable iff (rst)
    (state_r == CDU_LOAD && !ready_r) |-> nack_r)
    else $error("bus not refused during download");
  a_commit_selfclear: assert property (@(posedge clock) disable iff (rst)
    (commit_r && !(ctl_wr && !nack_r && wdata[UPD_COMMIT_BIT]))
      |=> (!commit_r && !ctl_r[UPD_COMMIT_BIT]))
    else $error("commit bit did not clear");
  // Back-to-back commit writes are legal, so tie each pulse to its own write
  a_commit_cause: assert property (@(posedge clock) disable iff (rst)
    commit_r |-> $past(ctl_wr && !nack_r && wdata[UPD_COMMIT_BIT]))
    else $error("commit pulse without commit write");
  a_commit_copies: assert property (@(posedge clock) disable iff (rst)
    commit_r |=> (active_r[0] == $past(stage_r[0])))
    else $error("commit did not copy staging");
  a_staged_holds: assert property (@(posedge clock) disable iff (rst)
    (!ctl_r[UPD_TRANSP_BIT] && !xfer_r && !commit_r) |=> $stable(active_r[0]))
    else $error("active changed without commit");
  a_transp_write: assert property (@(posedge clock) disable iff (rst)
    (ctl_r[UPD_TRANSP_BIT] && cfg_wr && !nack_r && addr == '0 && !xfer_r && !commit_r)
      |=> active_r[0] == $past(wdata))
    else $error("transparent write missed active");
  a_start_after: assert property (@(posedge clock) disable iff (rst)
    start_r |-> $past(state_r) == CDU_DELAY)
    else $error("engine started outside delay");
  a_wait_lockout: assert property (@(posedge clock) disable iff (rst)
    (state_r == CDU_WAIT && !supply_lockout_level) |=> state_r == CDU_WAIT)
    else $error("download began under lockout");
  a_xfer_last: assert property (@(posedge clock) disable iff (rst)
    xfer_r |-> $past(idx_r) == CFG_LAST)
    else $error("transfer before last byte");
  a_reload_begins: assert property (@(posedge clock) disable iff (rst)
    (state_r == CDU_RUN && reload_wr && (wdata[2:0] & RELOAD_BIT_MASK) != 3'h0)
      |=> (state_r == CDU_LOAD && idx_r == '0))
    else $error("reload request not taken");
  a_reload_acked: assert property (@(posedge clock) disable iff (rst)
    (state_r == CDU_LOAD && ready_r) |-> !nack_r)
    else $error("bus refused during user reload");
  // Other cell writes excluded so the check sees the erase alone
  a_erase_blank: assert property (@(posedge clock) disable iff (rst)
    (erase_go && !nv_wr && !commit_r)
      |=> nv_mem[{$past(erase_page), BYTE_AW'(0)}] == BLANK_BYTE)
    else $error("enabled erase left page unblanked");
  a_erase_gated: assert property (@(posedge clock) disable iff (rst)
    (nv_erase && !ctl_r[UPD_ERASE_BIT] && !nv_wr && !commit_r)
      |=> nv_mem[$past(addr)] == $past(nv_mem[addr]))
    else $error("disabled erase changed the cell");
  a_nv_staged: assert property (@(posedge clock) disable iff (rst)
    (nv_wr && !nack_r && !ctl_r[UPD_TRANSP_BIT] && !commit_r && !erase_go)
      |=> nv_mem[$past(addr)] == $past(nv_mem[addr]))
    else $error("staged nonvolatile write landed early");
endmodule : cdu_top
`default_nettype wire

/* test/cdu_host_model.sv */
// Bus master model: issues decoded byte accesses to the loader.
// Assumes the loader clock; one access at a time, strobes one cycle.
`timescale 1ns/1ps
`default_nettype none
module cdu_host_model
  import cdu_pkg::*;
(
  // Clock
  input  wire logic                      clock,
  // Decoded access
  output logic                           bus_start,
  output logic                           cfg_wr,
  output logic                           nv_wr,
  output logic                           nv_erase,
  output logic                           ctl_wr,
  output logic                           reload_wr,
  output logic [cdu_pkg::NV_AW-1:0]      addr,
  output logic [7:0]                     wdata,
  output logic                           rd,
  output logic                           rd_nv,
  output logic                           rd_ctl,
  // Answer
  input  wire logic [7:0]                rdata
);
  import cdu_pkg::*;
  initial
  begin
    {bus_start, cfg_wr, nv_wr, nv_erase, ctl_wr, reload_wr, rd, rd_nv, rd_ctl} = 9'h000;
    addr  = 9'h000;
    wdata = 8'h00;
  end
  // Strobe order: reload, control, erase, nv write, cfg write
  task automatic put(input logic [4:0] s, input int a, input logic [7:0] d);
    @(posedge clock);
    {reload_wr, ctl_wr, nv_erase, nv_wr, cfg_wr} <= s;
    bus_start <= 1'b1;
    addr      <= NV_AW'(a);
    wdata     <= d;
    @(posedge clock);
    {reload_wr, ctl_wr, nv_erase, nv_wr, cfg_wr} <= 5'h00;
    bus_start <= 1'b0;
    // Released lines must not keep their last value
    addr      <= ~NV_AW'(a);
    wdata     <= ~d;
  endtask : put
  task automatic get(input logic nv, input logic c, input int a, output logic [7:0] d);
    @(posedge clock);
    rd     <= 1'b1;
    rd_nv  <= nv;
    rd_ctl <= c;
    addr   <= NV_AW'(a);
    @(posedge clock);
    rd     <= 1'b0;
    rd_nv  <= 1'b0;
    rd_ctl <= 1'b0;
    addr   <= ~NV_AW'(a);
    #1 d = rdata;
  endtask : get
endmodule : cdu_host_model
`default_nettype wire

/* test/tb_top.sv */
// Testbench: power-up download, staged and transparent updates, reload.
// Assumes the host model drives all bus strobes; NV starts unknown.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cdu_pkg::*;
  localparam int ENG_D = 10;
  logic                  clock;
  logic                  rst;
  logic                  lock;
  wire logic             bus_start, cfg_wr, nv_wr, nv_erase, ctl_wr, reload_wr, rd, rd_nv, rd_ctl;
  wire logic [NV_AW-1:0] addr;
  wire logic [7:0]       wdata;
  wire logic [7:0]       rdata;
  wire logic             bus_nack;
  wire logic [CFG_BYTES*8-1:0] cfg_active;
  wire logic             cfg_ready;
  wire logic             sequencing_engine_start;
  int                    fail_count;
  int                    checks_done;
  int                    cyc;
  int                    seed;
  logic [7:0]            nv_m [int];
  logic [7:0]            act_m [int];
  cdu_top #(.ENG_DELAY(ENG_D)) i_dut (.clock, .rst, .supply_lockout_level(lock), .bus_start,
    .cfg_wr, .nv_wr, .nv_erase, .ctl_wr, .reload_wr, .addr, .wdata, .rd, .rd_nv, .rd_ctl,
    .bus_nack, .rdata, .cfg_active, .cfg_ready, .sequencing_engine_start);
  cdu_host_model i_host (.clock, .bus_start, .cfg_wr, .nv_wr, .nv_erase, .ctl_wr, .reload_wr,
    .addr, .wdata, .rd, .rd_nv, .rd_ctl, .rdata);
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_act(input int g);
    repeat (2) @(posedge clock);
    #1 chk("active", act_m[g], cfg_active[8*g +: 8]);
  endtask : chk_act
  task automatic chk_nv(input int a);
    logic [7:0] d;
    i_host.get(1'b1, 1'b0, a, d);
    chk("nv", nv_m[a], d);
  endtask : chk_nv
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  // Hang guard, well above the fewer than a thousand cycles the run needs
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  initial
  begin
    int         a;
    int         a2;
    int         n;
    logic [7:0] d;
    logic [7:0] w;
    seed = 43;
    rst  = 1'b1;
    lock = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    i_host.put(5'h08, 0, 8'h01);
    repeat (8) @(posedge clock);
    chk("nack", 8'h01, {7'h00, bus_nack});
    chk("ready_early", 8'h00, {7'h00, cfg_ready});
    lock <= 1'b1;
    n = 0;
    // Sample just after the edge so registered outputs have settled
    while (cfg_ready !== 1'b1 && n < 1000)
    begin
      @(posedge clock);
      #1 n++;
    end
    chk("ready", 8'h01, {7'h00, cfg_ready});
    chk("load_len", 8'h01, {7'h00, n == CFG_BYTES + 1});
    n = 0;
    while (sequencing_engine_start !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      #1 n++;
    end
    chk("engine_gap", 8'h01, {7'h00, n == ENG_D});
    i_host.get(1'b0, 1'b1, 0, d);
    chk("ctl_refused", 8'h00, d);
    a  = {$random(seed)} % CFG_BYTES;
    a2 = (a + 1) % CFG_BYTES;
    w  = 8'($random(seed));
    i_host.put(5'h08, 0, 8'h05);
    for (int p = 0; p < CFG_PAGES; p++)
    begin
      i_host.put(5'h04, p * PAGE_BYTES, 8'h00);
      for (int i = 0; i < PAGE_BYTES; i++)
        nv_m[p * PAGE_BYTES + i] = BLANK_BYTE;
    end
    // Power-up copy of a never-programmed cell is unknown, so reload blank pages
    i_host.put(5'h10, 0, 8'h01);
    repeat (CFG_BYTES + 8) @(posedge clock);
    act_m[a] = nv_m[a];
    chk_act(a);
    act_m[a] = w;
    i_host.put(5'h01, a, w);
    chk_act(a);
    d = 8'($random(seed));
    nv_m[a] = d;
    i_host.put(5'h02, a, d);
    chk_nv(a);
    chk_act(a);
    i_host.put(5'h02, a, ~d);
    nv_m[a] = 8'h00;
    chk_nv(a);
    i_host.put(5'h08, 0, 8'h04);
    i_host.put(5'h01, a, ~w);
    chk_act(a);
    d = 8'($random(seed));
    i_host.put(5'h02, a2, d);
    chk_nv(a2);
    i_host.put(5'h08, 0, 8'h06);
    repeat (3) @(posedge clock);
    act_m[a] = ~w;
    nv_m[a2] = d;
    chk_act(a);
    chk_nv(a2);
    i_host.get(1'b0, 1'b1, 0, w);
    chk("ctl", 8'h04, w);
    i_host.put(5'h08, 0, 8'h01);
    i_host.put(5'h04, a2, 8'h00);
    chk_nv(a2);
    i_host.put(5'h10, 0, 8'h00);
    chk_act(a);
    i_host.put(5'h10, 0, 8'h01);
    // No completion flag on a user reload, so wait out the copy
    repeat (CFG_BYTES + 8) @(posedge clock);
    act_m[a]  = nv_m[a];
    act_m[a2] = nv_m[a2];
    chk_act(a);
    chk_act(a2);
    w = 8'($random(seed));
    i_host.put(5'h01, 0, w);
    act_m[0] = w;
    i_host.get(1'b0, 1'b0, 0, d);
    chk("latch_rd", act_m[0], d);
    i_host.get(1'b0, 1'b0, CFG_BYTES, d);
    chk("beyond_cfg", ZERO_BYTE, d);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
